/* File: rtl/elu_pkg.sv */
// Shared constants for the edge latch interrupt unit
package elu_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Register offsets (status read and range write share one address)
  localparam logic [7:0] AFC_REMOTE_SYNC_STATUS_ADDR  = 8'h00e4;
  localparam logic [7:0] COMPARATOR_RANGE_SELECT_ADDR = 8'h00e4;
  localparam logic [7:0] EVENT_LATCH_CONTROL_ADDR     = 8'h00e9;

  // Event latch control fields
  localparam int unsigned REMOTE_RISING_EDGE_SELECT_BIT    = 1;
  localparam int unsigned REMOTE_IRQ_ENABLE_BIT            = 2;
  localparam int unsigned REMOTE_LATCH_CLEAR_BIT           = 3;
  localparam int unsigned POWER_KEY_RISING_EDGE_SELECT_BIT = 4;
  localparam int unsigned POWER_KEY_IRQ_ENABLE_BIT         = 5;
  localparam int unsigned POWER_KEY_LATCH_CLEAR_BIT        = 6;

  // Comparator range select field
  localparam int unsigned COMPARATOR_RANGE_BIT = 3;

  // Status register fields
  localparam int unsigned COMPARATOR_CODE_LSB = 0;
  localparam int unsigned COMPARATOR_CODE_W   = 3;
  localparam int unsigned REMOTE_LATCH_STATE_BIT = 3;
  localparam int unsigned VSYNC_STATUS_BIT    = 4;

  // Reset values
  localparam logic [7:0] STATUS_RESET      = 8'h0000;
  localparam logic [7:0] RANGE_RESET       = 8'h0000;
  localparam logic [7:0] LATCH_CTRL_RESET  = 8'h0000;
  localparam logic [7:0] READ_IDLE_VALUE   = 8'h0000;

  // Comparator thresholds, in millivolts
  localparam int unsigned AFC_LEVEL_W        = 14;
  localparam int unsigned AFC_THRESHOLDS     = 5;
  localparam int unsigned AFC_STEP_MV        = 1000;
  localparam int unsigned AFC_FIRST_MV       = 1000;
  localparam int unsigned AFC_LOWER_SHIFT_MV = 500;

  // Synchroniser depth for the latch pins
  localparam int unsigned SYNC_STAGES = 2;

endpackage : elu_pkg

/* File: rtl/elu_edge_latch.sv */
// One synchronised edge-triggered event latch with clear
module elu_edge_latch
  import elu_pkg::*;
(
  input  wire logic clk_sys_i,      // System clock
  input  wire logic resetn_i,       // Asynchronous reset, active low
  input  wire logic ce_i,           // Clock enable, freezes state when low
  input  wire logic pin_i,          // Raw event pin
  input  wire logic rising_sel_i,   // One picks rising edges, zero falling
  input  wire logic clear_i,        // One-cycle clear pulse
  output logic      latch_o         // Latch state
);

  logic [SYNC_STAGES-1:0] sync_q;   // Two-flop synchroniser chain
  logic                   last_q;   // Previous synchronised level
  logic                   edge_hit; // Qualifying edge this cycle
  logic [1:0]             fill_q;   // Samples taken since reset, saturating
  localparam logic [1:0]  FILL_DONE = 2'(SYNC_STAGES + 1); // Chain and last flop hold samples

  // Synchroniser; only the last stage is looked at
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync_q <= '0;
      last_q <= 1'b0;
    end else if (ce_i) begin
      sync_q <= {sync_q[SYNC_STAGES-2:0], pin_i};
      last_q <= sync_q[SYNC_STAGES-1];
    end
  end

  // Fill counter; counts clocked samples until the compare flops are real
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fill_q <= 2'h0;
    end else if (ce_i && (fill_q != FILL_DONE)) begin
      fill_q <= fill_q + 2'h1;
    end
  end

  // Edge detector on the settled level, one hit per edge; silent until
  // the chain is filled, so a pin resting high gives no edge after reset
  always_comb begin
    if (fill_q != FILL_DONE) begin
      edge_hit = 1'b0;
    end else if (rising_sel_i) begin
      edge_hit = sync_q[SYNC_STAGES-1] & ~last_q;
    end else begin
      edge_hit = ~sync_q[SYNC_STAGES-1] & last_q;
    end
  end

  // Latch; a new edge beats a clear in the same cycle
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      latch_o <= 1'b0;
    end else if (ce_i) begin
      if (edge_hit) begin
        latch_o <= 1'b1;
      end else if (clear_i) begin
        latch_o <= 1'b0;
      end
    end
  end

endmodule : elu_edge_latch

/* File: rtl/elu_afc_quantiser.sv */
// Five-level AFC comparator with selectable half-step offset
module elu_afc_quantiser
  import elu_pkg::*;
#(
  parameter int unsigned LEVEL_W = AFC_LEVEL_W
) (
  input  wire logic [LEVEL_W-1:0] level_mv_i,  // Input level in millivolts
  input  wire logic               normal_i,    // One: normal range, zero: lowered
  output logic [COMPARATOR_CODE_W-1:0] code_o  // Binary count of levels passed
);

  logic [AFC_THRESHOLDS-1:0] above; // One per threshold crossed

  // Refuse level widths too narrow to reach the top threshold
  if (LEVEL_W < AFC_LEVEL_W) begin : g_width_check
    $error("elu_afc_quantiser: LEVEL_W too small");
  end

  // One comparator per threshold, spaced a step apart
  for (genvar k = 0; k < AFC_THRESHOLDS; k++) begin : g_level
    localparam int unsigned NORM_MV = AFC_FIRST_MV + k * AFC_STEP_MV;
    localparam int unsigned LOW_MV  = NORM_MV - AFC_LOWER_SHIFT_MV;
    assign above[k] = normal_i ? (level_mv_i > LEVEL_W'(NORM_MV))
                               : (level_mv_i > LEVEL_W'(LOW_MV));
  end

  // Thresholds are ordered, so the count is the binary code
  always_comb begin
    code_o = '0;
    for (int i = 0; i < AFC_THRESHOLDS; i++) begin
      code_o = code_o + COMPARATOR_CODE_W'(above[i]);
    end
  end

endmodule : elu_afc_quantiser

/* File: rtl/elu_edge_latch_interrupt_unit.sv */
// Top of the edge latch interrupt unit: registers, latches, AFC status
//
// Decided for this implementation: the address-and-strobe port.

module elu_edge_latch_interrupt_unit
  import elu_pkg::*;
#(
  parameter int unsigned LEVEL_W = AFC_LEVEL_W // Width of the level input
) (
  input  wire logic               clk_sys_i,                 // System clock
  input  wire logic               resetn_i,                  // Async reset, low
  input  wire logic               ce_i,                      // Clock enable
  input  wire logic [ADDR_W-1:0]  reg_addr_i,                // Register address
  input  wire logic [DATA_W-1:0]  reg_wdata_i,               // Write data
  input  wire logic               reg_wr_i,                  // Write strobe
  input  wire logic               reg_rd_i,                  // Read strobe
  output logic      [DATA_W-1:0]  reg_rdata_o,               // Read data
  input  wire logic               remote_input_pin_i,        // Remote pin
  input  wire logic               power_key_input_pin_i,     // Power key pin
  input  wire logic               vsync_pin_i,               // Vertical sync pin
  input  wire logic [LEVEL_W-1:0] afc_level_mv_i,            // AFC level, mV
  output logic                    remote_irq_request_n_o,    // Remote request
  output logic                    power_key_irq_request_n_o, // Power request
  output logic                    comparator_range_bit_o     // Range in use
);

  // Declarations
  // Nets shared by the register file, the latches and the read path

  // Address decode results
  logic hit_status;        // Read of the status address
  logic hit_range;         // Write of the range select address
  logic hit_latch_ctrl;    // Write of the latch control address

  // Qualified strobes
  logic wr_range;          // Range select write this cycle
  logic wr_latch_ctrl;     // Latch control write this cycle
  logic rd_status;         // Status read this cycle

  // Latch control fields held by the block
  logic remote_rising_edge_select;     // Remote edge choice
  logic remote_irq_enable;             // Remote request enable
  logic power_key_rising_edge_select;  // Power key edge choice
  logic power_key_irq_enable;          // Power key request enable

  // One-cycle clear pulses derived from the write
  logic remote_latch_clear;            // Remote clear pulse
  logic power_key_latch_clear;         // Power key clear pulse

  // Range select storage
  logic comparator_range_bit;          // One: normal, zero: lowered

  // Latch states from the two latch instances
  logic remote_latch_state;            // Remote latch
  logic power_key_latch_state;         // Power key latch

  // Comparator output
  logic [COMPARATOR_CODE_W-1:0] comparator_code_live; // Combinational code
  logic [COMPARATOR_CODE_W-1:0] comparator_code;      // Registered code

  // Status word and read path
  logic [DATA_W-1:0] status_word;      // Assembled status value
  logic [DATA_W-1:0] next_rdata;       // Value for the read data flop

  // Address decode
  // Status read and range write share one address, told apart by strobe

  // Status is read at its address; unmapped reads return zero
  always_comb begin
    if (reg_addr_i == AFC_REMOTE_SYNC_STATUS_ADDR) begin
      hit_status = 1'b1;
    end else begin
      hit_status = 1'b0;
    end
  end

  // Write targets; unmapped writes are dropped
  always_comb begin
    hit_range      = 1'b0;
    hit_latch_ctrl = 1'b0;
    if (reg_addr_i == COMPARATOR_RANGE_SELECT_ADDR) begin
      hit_range = 1'b1;
    end else if (reg_addr_i == EVENT_LATCH_CONTROL_ADDR) begin
      hit_latch_ctrl = 1'b1;
    end
  end

  // Strobes qualified by decode and clock enable
  assign wr_range      = ce_i & reg_wr_i & hit_range;
  assign wr_latch_ctrl = ce_i & reg_wr_i & hit_latch_ctrl;
  assign rd_status     = ce_i & reg_rd_i & hit_status;

  // Latch control register (write-only)
  // Only edge and enable bits are stored; clear bits act as pulses

  // Remote edge select and enable; bits 7 and 0 ignored
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      remote_rising_edge_select <= LATCH_CTRL_RESET[REMOTE_RISING_EDGE_SELECT_BIT];
      remote_irq_enable         <= LATCH_CTRL_RESET[REMOTE_IRQ_ENABLE_BIT];
    end else if (wr_latch_ctrl) begin
      // Edge and enable captured from the write
      remote_rising_edge_select <= reg_wdata_i[REMOTE_RISING_EDGE_SELECT_BIT];
      remote_irq_enable         <= reg_wdata_i[REMOTE_IRQ_ENABLE_BIT];
    end
  end

  // Power key edge select and enable
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      power_key_rising_edge_select <= LATCH_CTRL_RESET[POWER_KEY_RISING_EDGE_SELECT_BIT];
      power_key_irq_enable         <= LATCH_CTRL_RESET[POWER_KEY_IRQ_ENABLE_BIT];
    end else if (wr_latch_ctrl) begin
      // Edge and enable captured from the write
      power_key_rising_edge_select <= reg_wdata_i[POWER_KEY_RISING_EDGE_SELECT_BIT];
      power_key_irq_enable         <= reg_wdata_i[POWER_KEY_IRQ_ENABLE_BIT];
    end
  end

  // Clear bits act only in the write cycle and are not stored,
  // so each clear needs its own write of a one
  assign remote_latch_clear =
    wr_latch_ctrl & reg_wdata_i[REMOTE_LATCH_CLEAR_BIT];
  assign power_key_latch_clear =
    wr_latch_ctrl & reg_wdata_i[POWER_KEY_LATCH_CLEAR_BIT];

  // Comparator range select register (write-only)
  // One stored bit picks the threshold set for the quantiser

  // Only the range bit is kept; reset selects the lowered set
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      comparator_range_bit <= RANGE_RESET[COMPARATOR_RANGE_BIT];
    end else if (wr_range) begin
      comparator_range_bit <= reg_wdata_i[COMPARATOR_RANGE_BIT];
    end
  end

  // Range in use is visible to the analog side
  assign comparator_range_bit_o = comparator_range_bit;

  // Event latches
  // Both latches share one design; only pins and controls differ

  // Remote event latch
  elu_edge_latch u_remote_latch (
    .clk_sys_i    (clk_sys_i),
    .resetn_i     (resetn_i),
    .ce_i         (ce_i),
    .pin_i        (remote_input_pin_i),
    .rising_sel_i (remote_rising_edge_select),
    .clear_i      (remote_latch_clear),
    .latch_o      (remote_latch_state)
  );

  // Power key event latch
  elu_edge_latch u_power_key_latch (
    .clk_sys_i    (clk_sys_i),
    .resetn_i     (resetn_i),
    .ce_i         (ce_i),
    .pin_i        (power_key_input_pin_i),
    .rising_sel_i (power_key_rising_edge_select),
    .clear_i      (power_key_latch_clear),
    .latch_o      (power_key_latch_state)
  );

  // Interrupt requests
  // Combinational from flops, so a request follows its latch at once

  // Remote request: inverted latch when enabled, else held high
  always_comb begin
    if (remote_irq_enable) begin
      remote_irq_request_n_o = ~remote_latch_state;
    end else begin
      remote_irq_request_n_o = 1'b1;
    end
  end

  // Power key request: inverted latch when enabled, else held high
  always_comb begin
    if (power_key_irq_enable) begin
      power_key_irq_request_n_o = ~power_key_latch_state;
    end else begin
      power_key_irq_request_n_o = 1'b1;
    end
  end

  // AFC comparator
  // Live comparison, registered once before it reaches the status word

  // Quantiser compares the level against the selected set
  elu_afc_quantiser #(
    .LEVEL_W (LEVEL_W)
  ) u_afc_quantiser (
    .level_mv_i (afc_level_mv_i),
    .normal_i   (comparator_range_bit),
    .code_o     (comparator_code_live)
  );

  // Code is sampled every enabled cycle so status stays live
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      comparator_code <= STATUS_RESET[COMPARATOR_CODE_LSB +: COMPARATOR_CODE_W];
    end else if (ce_i) begin
      comparator_code <= comparator_code_live;
    end
  end

  // Status word and read path
  // Read data stand one cycle after the strobe, then return to idle

  // Status layout; top three bits read as zero
  always_comb begin
    status_word = '0;
    status_word[COMPARATOR_CODE_LSB +: COMPARATOR_CODE_W] = comparator_code;
    status_word[REMOTE_LATCH_STATE_BIT] = remote_latch_state;
    status_word[VSYNC_STATUS_BIT]       = ~vsync_pin_i;
  end

  // Data appear only in the cycle after a read strobe
  always_comb begin
    if (rd_status) begin
      next_rdata = status_word;
    end else begin
      // Write-only and unmapped addresses read as idle
      next_rdata = READ_IDLE_VALUE;
    end
  end

  // Read data flop; frozen while the clock enable is low
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= STATUS_RESET;
    end else if (ce_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

endmodule : elu_edge_latch_interrupt_unit

/* File: tb/elu_properties.sv */
// Port-level checker for the edge latch interrupt unit
module elu_properties
  import elu_pkg::*;
#(
  parameter int unsigned LEVEL_W = AFC_LEVEL_W // Level input width
) (
  input wire logic               clk_sys_i,
  input wire logic               resetn_i,
  input wire logic               ce_i,
  input wire logic [ADDR_W-1:0]  reg_addr_i,
  input wire logic [DATA_W-1:0]  reg_wdata_i,
  input wire logic               reg_wr_i,
  input wire logic               reg_rd_i,
  input wire logic [DATA_W-1:0]  reg_rdata_o,
  input wire logic               remote_input_pin_i,
  input wire logic               power_key_input_pin_i,
  input wire logic               vsync_pin_i,
  input wire logic [LEVEL_W-1:0] afc_level_mv_i,
  input wire logic               remote_irq_request_n_o,
  input wire logic               power_key_irq_request_n_o,
  input wire logic               comparator_range_bit_o
);
  logic wr_ok;   // Write strobe taken
  logic ctl_wr;  // Control write taken
  logic rng_wr;  // Range write taken
  logic st_rd;   // Status read taken
  logic oth_rd;  // Read of any other address
  logic rng_d;   // Range bit on the write bus
  logic r_clr;   // Remote clear with enable kept on
  logic p_clr;   // Power clear with enable kept on
  logic r_en;    // Shadow remote enable
  logic r_rise;  // Shadow remote edge select
  logic p_en;    // Shadow power enable
  logic p_rise;  // Shadow power edge select
  assign wr_ok  = ce_i && reg_wr_i;
  assign ctl_wr = wr_ok && (reg_addr_i == EVENT_LATCH_CONTROL_ADDR);
  assign rng_wr = wr_ok && (reg_addr_i == COMPARATOR_RANGE_SELECT_ADDR);
  assign st_rd  = ce_i && reg_rd_i && (reg_addr_i == AFC_REMOTE_SYNC_STATUS_ADDR);
  assign oth_rd = ce_i && reg_rd_i && (reg_addr_i != AFC_REMOTE_SYNC_STATUS_ADDR);
  assign rng_d  = reg_wdata_i[COMPARATOR_RANGE_BIT];
  assign r_clr  = ctl_wr && reg_wdata_i[3] && reg_wdata_i[2];
  assign p_clr  = ctl_wr && reg_wdata_i[6] && reg_wdata_i[5];
  // Shadow of the control fields, updated as the design is told
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {r_en, r_rise, p_en, p_rise} <= 4'h0;
    end else if (ctl_wr) begin
      {r_en, r_rise, p_en, p_rise} <= {reg_wdata_i[2:1], reg_wdata_i[5:4]};
    end
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  a_remote_held_high: assert property (!r_en |-> remote_irq_request_n_o)
    else $error("remote request low while disabled");
  a_power_held_high: assert property (!p_en |-> power_key_irq_request_n_o)
    else $error("power request low while disabled");
  a_rdata_idle: assert property ($past(ce_i) && !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
    else $error("read data not idle");
  a_other_read_zero: assert property ($past(oth_rd) |-> reg_rdata_o == 8'h00)
    else $error("write-only or unmapped read not zero");
  a_status_fields: assert property ($past(st_rd) |->
    reg_rdata_o[7:5] == 3'h0 && reg_rdata_o[4] == !$past(vsync_pin_i))
    else $error("status top bits or sync bit wrong");
  a_latch_visible: assert property ($past(st_rd) && $past(r_en) |->
    reg_rdata_o[3] == !$past(remote_irq_request_n_o))
    else $error("status latch bit disagrees with request");
  a_range_taken: assert property (rng_wr |=> comparator_range_bit_o == $past(rng_d))
    else $error("range bit not taken");
  a_remote_clear: assert property ($stable(remote_input_pin_i)[*4] ##0 r_clr
    |=> remote_irq_request_n_o)
    else $error("remote latch not cleared");
  a_power_clear: assert property ($stable(power_key_input_pin_i)[*4] ##0 p_clr
    |=> power_key_irq_request_n_o)
    else $error("power latch not cleared");
  a_remote_sets: assert property ($rose(remote_input_pin_i) && r_rise
    && r_en |-> ##[2:4] !remote_irq_request_n_o)
    else $error("remote edge not latched");
  a_power_sets: assert property ($fell(power_key_input_pin_i) && !p_rise
    && p_en |-> ##[2:4] !power_key_irq_request_n_o)
    else $error("power edge not latched");
  c_remote_low: cover property ($fell(remote_irq_request_n_o));
  c_power_low: cover property ($fell(power_key_irq_request_n_o));
  c_status_read: cover property (st_rd);
endmodule : elu_properties

bind elu_edge_latch_interrupt_unit elu_properties #(.LEVEL_W(LEVEL_W)) u_props (
  .clk_sys_i, .resetn_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .remote_input_pin_i, .power_key_input_pin_i, .vsync_pin_i,
  .afc_level_mv_i, .remote_irq_request_n_o, .power_key_irq_request_n_o,
  .comparator_range_bit_o
);

/* File: tb/elu_pin_model.sv */
// Remote receiver and power key line model
module elu_pin_model (
  input  wire logic clk_sys_i,  // System clock
  output logic      remote_o,   // Remote receiver line
  output logic      power_o     // Power key line, released high
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle levels at time zero
  initial begin
    remote_o = 1'b0;
    power_o  = 1'b1;
  end
  // Move one line after an edge and hold it long enough to be seen
  task automatic drive(input logic which, input logic v);
    @(posedge clk_sys_i);
    if (which) power_o <= v;
    else remote_o <= v;
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask : drive
endmodule : elu_pin_model

/* File: tb/elu_edge_latch_interrupt_unit_tb.sv */
// Register-level testbench for the edge latch interrupt unit
module elu_edge_latch_interrupt_unit_tb;
  import elu_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk_sys_i = 1'b0;   // System clock
  logic                   resetn_i  = 1'b0;   // Reset, active low
  logic                   ce_i      = 1'b1;   // Clock enable
  logic [ADDR_W-1:0]      reg_addr_i  = '0;   // Register address
  logic [DATA_W-1:0]      reg_wdata_i = '0;   // Write data
  logic                   reg_wr_i  = 1'b0;   // Write strobe
  logic                   reg_rd_i  = 1'b0;   // Read strobe
  logic                   vsync_pin_i = 1'b1; // Sync pin
  logic [AFC_LEVEL_W-1:0] afc_level_mv_i = '0; // AFC level
  logic [DATA_W-1:0]      reg_rdata_o;        // Read data
  logic                   remote_input_pin_i; // Remote line
  logic                   power_key_input_pin_i; // Power line
  logic                   remote_irq_request_n_o;
  logic                   power_key_irq_request_n_o;
  logic                   comparator_range_bit_o;
  int                     err_total   = 0;    // Mismatches
  int                     check_count = 0;    // Comparisons
  int                     lv[7] = '{0, 999, 1001, 2500, 4999, 5001, 600}; // Levels, mV
  always #2 clk_sys_i = ~clk_sys_i;
  elu_edge_latch_interrupt_unit dut (
    .clk_sys_i, .resetn_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .remote_input_pin_i, .power_key_input_pin_i, .vsync_pin_i,
    .afc_level_mv_i, .remote_irq_request_n_o, .power_key_irq_request_n_o,
    .comparator_range_bit_o
  );
  elu_pin_model pins (
    .clk_sys_i,
    .remote_o (remote_input_pin_i),
    .power_o  (power_key_input_pin_i)
  );
  // Compare one value and count it
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask : wr
  // One-cycle read strobe, data taken in the following cycle, masked
  task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_sys_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o & m, e);
  endtask : rdchk
  // Number of thresholds strictly exceeded
  function automatic logic [7:0] code_of(input int lvl, input int normal);
    int n;
    n = 0;
    for (int k = 0; k < 5; k++) begin
      if (lvl > (normal ? 1000 : 500) + 1000 * k) n++;
    end
    return 8'(n);
  endfunction : code_of
  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  // Watchdog against a hang
  initial begin
    #20000;
    err_total++;
    results();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    rdchk(8'he4, 8'hff, 8'h00);
    rdchk(8'he9, 8'hff, 8'h00);
    rdchk(8'h55, 8'hff, 8'h00);
    chk(remote_irq_request_n_o, 8'h01);
    chk(power_key_irq_request_n_o, 8'h01);
    // Remote rising edge, enabled
    wr(8'he9, 8'h06);
    pins.drive(1'b0, 1'b1);
    chk(remote_irq_request_n_o, 8'h00);
    rdchk(8'he4, 8'h08, 8'h08);
    wr(8'he9, 8'h0e);
    chk(remote_irq_request_n_o, 8'h01);
    // Falling edge while rising is selected is ignored
    pins.drive(1'b0, 1'b0);
    chk(remote_irq_request_n_o, 8'h01);
    rdchk(8'he4, 8'h08, 8'h00);
    // Falling edge with the request disabled
    wr(8'he9, 8'h00);
    pins.drive(1'b0, 1'b1);
    pins.drive(1'b0, 1'b0);
    chk(remote_irq_request_n_o, 8'h01);
    rdchk(8'he4, 8'h08, 8'h08);
    wr(8'he9, 8'h04);
    chk(remote_irq_request_n_o, 8'h00);
    // Clear lands on the same edge as a new event
    wr(8'he9, 8'h0e);
    fork
      pins.drive(1'b0, 1'b1);
      begin
        repeat (2) @(posedge clk_sys_i);
        wr(8'he9, 8'h0e);
      end
    join
    chk(remote_irq_request_n_o, 8'h00);
    // Clock enable low: a clear write is not taken, latch stays set
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    wr(8'he9, 8'h0e);
    @(posedge clk_sys_i);
    ce_i <= 1'b1;
    #1;
    chk(remote_irq_request_n_o, 8'h00);
    // Power key, rising selected, then falling selected
    wr(8'he9, 8'h30);
    pins.drive(1'b1, 1'b0);
    chk(power_key_irq_request_n_o, 8'h01);
    pins.drive(1'b1, 1'b1);
    chk(power_key_irq_request_n_o, 8'h00);
    wr(8'he9, 8'h70);
    chk(power_key_irq_request_n_o, 8'h01);
    wr(8'he9, 8'h20);
    pins.drive(1'b1, 1'b0);
    chk(power_key_irq_request_n_o, 8'h00);
    wr(8'he9, 8'h00);
    chk(power_key_irq_request_n_o, 8'h01);
    // Sync bit reads inverted
    @(posedge clk_sys_i);
    vsync_pin_i <= 1'b0;
    rdchk(8'he4, 8'h10, 8'h10);
    // Comparator codes in both ranges
    for (int r = 1; r >= 0; r--) begin
      wr(8'he4, r ? 8'h08 : 8'hf7);
      chk(comparator_range_bit_o, 8'(r));
      foreach (lv[i]) begin
        @(posedge clk_sys_i);
        afc_level_mv_i <= AFC_LEVEL_W'(lv[i]);
        repeat (2) @(posedge clk_sys_i);
        rdchk(8'he4, 8'h07, code_of(lv[i], r));
      end
    end
    results();
  end
endmodule : elu_edge_latch_interrupt_unit_tb
